/* verification/srtr_relay_props.sv */
// relay output checks
`timescale 1ns/100ps
module srtr_relay_props
(
   input wire logic i_core_clk, i_nrst, i_power_up, o_relay,
   input wire logic i_saved_valid, i_saved_state,
   input wire srtr_pkg::srtr_in_t i_in,
   input wire srtr_pkg::srtr_cfg_t i_cfg
);
   wire s = i_in.set, c = i_in.clear;
   wire [1:0] m = i_power_up ? 2'h3 : i_cfg.mode;
   wire keep = i_cfg.retain && i_saved_valid && i_saved_state &&
      i_cfg.mode != 2'h2;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_rise; !i_in.trigger ##1 i_in.trigger && !s && !c; endsequence
   property p_set; m == 2'h0 && s && !c |=> o_relay; endproperty
   a_set: assert property (p_set) else $error("set");
   property p_clr; (m == 2'h0 || m == 2'h2) && c |=> !o_relay; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_hold; m == 2'h0 && !s && !c |=> $stable(o_relay); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_tgl; s_rise ##0 m[0] ^ m[1] |=> o_relay ^ $past(o_relay);
   endproperty
   a_tgl: assert property (p_tgl) else $error("toggle");
   property p_one; m == 2'h1 && s && !c |=> o_relay; endproperty
   a_one: assert property (p_one) else $error("one");
   property p_zero; m == 2'h1 && c && !s |=> !o_relay; endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_prio; m == 2'h1 && s && c |=> o_relay == $past(i_cfg.prio);
   endproperty
   a_prio: assert property (p_prio) else $error("prio");
   property p_pwr; i_power_up |=> o_relay == $past(keep); endproperty
   a_pwr: assert property (p_pwr) else $error("restore");
endmodule
bind srtr_relay srtr_relay_props i_props (.*);

/* verification/srtr_store.sv */
// retentive store model feeding the restore inputs
`timescale 1ns/100ps
module srtr_store
(
   input wire logic i_core_clk,
   input wire logic i_state,
   output logic o_valid,
   output logic o_state
);
   always_ff @(posedge i_core_clk)
      {o_valid, o_state} <= {1'h1, i_state};
endmodule

/* verification/tb_top.sv */
// random bench against a reference model
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'h0, nrst = 1'h0, pu = 1'h0, sv, ss, q, qs;
   srtr_pkg::srtr_in_t in = 3'h0;
   srtr_pkg::srtr_cfg_t cfg = 4'h0;
   int failures = 0, n_checks = 0, cyc = 0, e = 0, t = 0;
   srtr_relay i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_in(in),
      .i_cfg(cfg), .i_power_up(pu), .i_saved_valid(sv),
      .i_saved_state(ss), .o_relay(q), .o_save_state(qs));
   srtr_store i_st (.i_core_clk(clk), .i_state(qs), .o_valid(sv),
      .o_state(ss));
   task finish_test;
      $display("%0d checks %0d failures", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
      forever #5 clk = !clk;
   initial
   begin
      void'($urandom(32'hDA4E0DBE));
      repeat (3000) @(posedge clk);
      finish_test;
   end
   always @(posedge clk)
   begin
      cyc++;
      n_checks++;
      if (cyc > 1 && (q !== e[0] || qs !== e[0]))
      begin
         failures++;
         $display("wrong value at %0t relay", $time);
      end
      if (!nrst)
         e = 0;
      else if (pu)
         e = cfg.retain && sv && ss && cfg.mode != 2'h2;
      else if (in.clear && !(in.set && cfg.mode == 2'h1 && cfg.prio))
         e = 0;
      else if (in.set && cfg.mode != 2'h2)
         e = 1;
      else if (cfg.mode != 2'h0 && in.trigger && !t)
         e = !e;
      t = nrst && in.trigger;
      if (cyc == 4000)
      begin
         failures++;
         finish_test;
      end
      nrst <= cyc > 1 && $urandom % 300 != 0;
      pu <= $urandom % 20 == 0;
      in <= {1'($urandom % 5 == 0), 1'($urandom % 5 == 0), 1'($urandom)};
      if (cyc % 40 == 0)
         cfg <= {2'($urandom % 3), 2'($urandom)};
   end
endmodule

/* verilog/srtr_edge.sv */
// rising edge detector for the trigger input
`timescale 1ns/100ps
module srtr_edge
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_level,
   output logic o_rise
);
   logic prev;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
         prev <= srtr_pkg::SRTR_TRG_RESET;
      else
         prev <= i_level;
   end

   // compare with last cycle's sample
   assign o_rise = i_level & ~prev;
endmodule

/* verilog/srtr_pkg.sv */
// shared types and constants of the set/reset/toggle relay
package srtr_pkg;
   typedef enum logic [1:0] {
      SRTR_MODE_LATCH,
      SRTR_MODE_TOGGLE,
      SRTR_MODE_LEGACY
   } srtr_mode_t;

   typedef enum logic {
      SRTR_CLEAR_WINS,
      SRTR_SET_WINS
   } srtr_prio_t;

   typedef struct packed {
      logic set;
      logic clear;
      logic trigger;
   } srtr_in_t;

   typedef struct packed {
      srtr_mode_t mode;
      srtr_prio_t prio;
      logic retain;
   } srtr_cfg_t;

   localparam logic SRTR_OUT_RESET = 1'h0;
   localparam logic SRTR_TRG_RESET = 1'h0;
endpackage

/* verilog/srtr_relay.sv */
// set/reset/toggle relay with latching, toggle and legacy modes
// Functional notes
// RQ1 - latching: set drives output high, clear drives it low
// RQ2 - latching: set and clear together force output low
// RQ3 - latching: no input asserted holds the output
// RQ4 - latching with retention restores pre-power-loss output
// RQ5 - toggle: output inverts on trigger rise when set and clear low
// RQ6 - toggle: trigger ignored while set or clear high
// RQ7 - toggle: set drives output to one
// RQ8 - toggle: clear returns output to zero
// RQ9 - toggle: priority choice, clear_wins or set_wins
// RQ10 - legacy toggle: no set, trigger toggles, clear turns off
// RQ11 - legacy toggle: output zero after power-on and on clear
// RQ12 - toggle with retention keeps output across power loss
// RQ13 - toggle, trigger low, clear_wins acts as latching
// RQ14 - all inputs sampled on one edge; trigger edge vs last cycle
`timescale 1ns/100ps
module srtr_relay
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire srtr_pkg::srtr_in_t i_in,
   input wire srtr_pkg::srtr_cfg_t i_cfg,
   input wire logic i_power_up,
   input wire logic i_saved_valid,
   input wire logic i_saved_state,
   output logic o_relay,
   output logic o_save_state
);
   logic trg_rise;
   logic next_relay;
   logic next_restore;

   // trigger edge against registered previous value [RQ14]
   srtr_edge u_edge
   (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_level(i_in.trigger),
      .o_rise(trg_rise)
   );

   function automatic logic srtr_set_clear(input logic q,
      input logic s, input logic c, input srtr_pkg::srtr_prio_t p);
      logic r;
      r = q;
      if (p == srtr_pkg::SRTR_SET_WINS && s)
         r = 1'h1;
      else if (c)
         r = 1'h0;
      else if (s)
         r = 1'h1;
      return r;
   endfunction

   always_comb
   begin
      next_relay = o_relay;
      case (i_cfg.mode)
         srtr_pkg::SRTR_MODE_LATCH:
         begin
            // clear wins, hold otherwise [RQ1] [RQ2] [RQ3] [RQ13]
            next_relay = srtr_set_clear(o_relay, i_in.set, i_in.clear,
               srtr_pkg::SRTR_CLEAR_WINS);
         end
         srtr_pkg::SRTR_MODE_TOGGLE:
         begin
            if (i_in.set || i_in.clear)
               // trigger ignored here [RQ6] [RQ7] [RQ8] [RQ9]
               next_relay = srtr_set_clear(o_relay, i_in.set,
                  i_in.clear, i_cfg.prio);
            else if (trg_rise)
               next_relay = ~o_relay; // [RQ5]
         end
         srtr_pkg::SRTR_MODE_LEGACY:
         begin
            // set input and priority not used [RQ10] [RQ11]
            if (i_in.clear)
               next_relay = 1'h0;
            else if (trg_rise)
               next_relay = ~o_relay;
         end
         default:
            next_relay = o_relay;
      endcase
   end

   // value taken on power return, legacy always starts at zero
   always_comb
   begin
      if (i_cfg.retain && i_saved_valid &&
          i_cfg.mode != srtr_pkg::SRTR_MODE_LEGACY)
         next_restore = i_saved_state; // [RQ4] [RQ12]
      else
         next_restore = srtr_pkg::SRTR_OUT_RESET; // [RQ11]
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
         o_relay <= srtr_pkg::SRTR_OUT_RESET; // [RQ11]
      else if (i_power_up)
         o_relay <= next_restore; // [RQ4] [RQ12]
      else
         o_relay <= next_relay;
   end

   // copy to retentive store outside the block
   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
         o_save_state <= srtr_pkg::SRTR_OUT_RESET;
      else if (i_power_up)
         // store must follow the restored output
         o_save_state <= next_restore;
      else
         o_save_state <= next_relay; // [RQ4] [RQ12]
   end
endmodule
